// ### xlate_pkg.sv
// constants shared by the translation buffer design
`default_nettype none
package xlate_pkg;
  // buffer geometry
  localparam int unsigned NUM_ENT = 8;
  localparam int unsigned IDX_W   = 3;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ROOT   = 8'h04;
  localparam logic [7:0] OFF_INVAL  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_HITS   = 8'h10;
  localparam logic [7:0] OFF_MISSES = 8'h14;
  // control register fields
  localparam int unsigned CTL_PROT   = 0;
  localparam int unsigned CTL_PAGING = 1;
  localparam int unsigned CTL_WP     = 2;
  localparam int unsigned CTL_GLOB   = 3;
  localparam int unsigned CTL_XDE    = 4;
  localparam int unsigned CTL_W      = 5;
  localparam logic [4:0]  CTL_RST = 5'h00;
  localparam logic [31:0] ROOT_RST = 32'h0000_0000;
  // paging entry fields
  localparam int unsigned ENT_P  = 0;
  localparam int unsigned ENT_RW = 1;
  localparam int unsigned ENT_US = 2;
  localparam int unsigned ENT_PS = 7;
  localparam int unsigned ENT_G  = 8;
  localparam int unsigned ENT_XD = 63;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // fault codes
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_NOTP  = 3'h1;
  localparam logic [2:0] FLT_WRITE = 3'h2;
  localparam logic [2:0] FLT_USER  = 3'h3;
  localparam logic [2:0] FLT_EXEC  = 3'h4;
  // walker states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOOK = 4'h2,
    ST_DIR  = 4'h4,
    ST_TBL  = 4'h8
  } walk_state_t;
endpackage
`default_nettype wire

// ### translation_buffer.sv
// translation buffer with page walker, invalidation and page checks
// Contract
// - cache recent directory and table entries
// - walk memory only on a buffer miss
// - split buffers optional; one shared here
// - only privilege 0 may invalidate
// - root write drops non-global entries
// - task switch reload acts like root write
// - page invalidate drops that page
// - page invalidate ignores global flag
// - global flag bit 8, gated by enable
// - global entries stay until explicit removal; here a round-robin fill can also replace one
// - clearing global enable flushes everything
// - checks finish before memory access starts
// - violation faults and access is withheld
// - paging enable turns on page checks; here only with protected-mode enable also set
// - pages have user and supervisor classes
// - all-writable user entries disable protection
// - protected-mode enable switches protection on
// - bit 63 is execute-disable when supported
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module translation_buffer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // implicit root reload on task switch
  input  wire logic        task_switch,
  input  wire logic [31:0] task_root,
  // translation request and answer
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [31:0] req_vaddr,
  input  wire logic        req_write,
  input  wire logic        req_user,
  input  wire logic        req_fetch,
  output logic             rsp_valid,
  output logic [31:0]      rsp_paddr,
  output logic             rsp_fault,
  output logic [2:0]       rsp_code,
  // paging structure reads
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [63:0] mem_rdata
);
  localparam int unsigned N = xlate_pkg::NUM_ENT;

  // a 4k entry matches on all 20 bits, a 4m entry on the upper 10
  function automatic logic page_match(input logic lg, input logic [19:0] tag,
                                      input logic [19:0] vpn);
    page_match = lg ? (tag[19:10] == vpn[19:10]) : (tag == vpn);
  endfunction

  // buffer storage, one flip-flop set per entry
  logic [N-1:0] ent_valid_r;
  logic [N-1:0] ent_valid_nxt;
  logic [N-1:0] ent_large_r;
  logic [N-1:0] ent_glob_r;
  logic [N-1:0] ent_rw_r;
  logic [N-1:0] ent_us_r;
  logic [N-1:0] ent_xd_r;
  logic [19:0]  ent_tag_r   [N];
  logic [19:0]  ent_frame_r [N];
  logic [xlate_pkg::IDX_W-1:0] victim_r;      // round-robin fill slot

  // control and walker state
  logic [xlate_pkg::CTL_W-1:0] ctrl_r;
  logic [31:0]            root_r;             // translation_root_reg
  xlate_pkg::walk_state_t state_r;
  logic [31:0]            va_r;
  logic                   wr_q_r;
  logic                   user_q_r;
  logic                   fetch_q_r;
  logic                   pde_rw_r;
  logic                   pde_us_r;
  logic                   pde_xd_r;
  logic [31:0]            hits_r;
  logic [31:0]            misses_r;

  // bus slave holding registers
  logic       aw_full_r;
  logic       w_full_r;
  logic [7:0] aw_addr_r;
  logic       aw_priv_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // control decode
  wire prot_on    = ctrl_r[xlate_pkg::CTL_PROT];
  wire paging_on  = ctrl_r[xlate_pkg::CTL_PAGING] & prot_on;
  wire wp_on      = ctrl_r[xlate_pkg::CTL_WP];
  wire glob_en_on = ctrl_r[xlate_pkg::CTL_GLOB];
  wire xde_on     = ctrl_r[xlate_pkg::CTL_XDE];

  // write decode: both halves held and no answer pending
  wire wr_fire  = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire a_ctrl   = (aw_addr_r == xlate_pkg::OFF_CTRL);
  wire a_root   = (aw_addr_r == xlate_pkg::OFF_ROOT);
  wire a_inval  = (aw_addr_r == xlate_pkg::OFF_INVAL);
  wire wr_map   = a_ctrl | a_root | a_inval;
  wire wr_ok    = wr_fire & wr_map & aw_priv_r;
  wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                       {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] ctrl_wide = {{(32 - xlate_pkg::CTL_W){1'b0}}, ctrl_r};
  wire [31:0] ctrl_merge = (ctrl_wide & ~wmask) | (w_data_r & wmask);
  wire [31:0] root_merge = (root_r & ~wmask) | (w_data_r & wmask);

  // invalidation events
  wire root_ld      = (wr_ok & a_root) | task_switch;
  wire glob_en_fall = wr_ok & a_ctrl & glob_en_on & ~ctrl_merge[xlate_pkg::CTL_GLOB];
  wire page_inv     = wr_ok & a_inval;
  wire any_inv      = root_ld | glob_en_fall | page_inv;

  // per-entry hit and kill masks
  logic [N-1:0] hit_vec;
  logic [N-1:0] inv_match;
  logic [N-1:0] kill_vec;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ent
      assign hit_vec[gi] = ent_valid_r[gi] &
        page_match(ent_large_r[gi], ent_tag_r[gi], va_r[31:12]);
      assign inv_match[gi] =
        page_match(ent_large_r[gi], ent_tag_r[gi], w_data_r[31:12]);
      assign kill_vec[gi] = glob_en_fall |
        (root_ld & ~(ent_glob_r[gi] & glob_en_on)) |
        (page_inv & inv_match[gi]);
    end
  endgenerate

  // select the hitting entry's frame and flags
  logic        hit_any;
  logic [19:0] hit_frame;
  logic        hit_large;
  logic        hit_rw;
  logic        hit_us;
  logic        hit_xd;
  always_comb begin
    hit_any   = 1'b0;
    hit_frame = 20'h00000;
    hit_large = 1'b0;
    hit_rw    = 1'b0;
    hit_us    = 1'b0;
    hit_xd    = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (hit_vec[i] && !hit_any) begin
        hit_any   = 1'b1;
        hit_frame = ent_frame_r[i];
        hit_large = ent_large_r[i];
        hit_rw    = ent_rw_r[i];
        hit_us    = ent_us_r[i];
        hit_xd    = ent_xd_r[i];
      end
    end
  end

  // page checks run beside the lookup, same cycle
  wire f_user = user_q_r & ~hit_us;
  wire f_wr   = wr_q_r & ~hit_rw & (user_q_r | wp_on);
  wire f_exec = fetch_q_r & hit_xd & xde_on;
  wire [2:0] chk_code = f_user ? xlate_pkg::FLT_USER :
                        f_wr   ? xlate_pkg::FLT_WRITE :
                        f_exec ? xlate_pkg::FLT_EXEC : xlate_pkg::FLT_NONE;
  wire [31:0] hit_pa = hit_large ? {hit_frame[19:10], va_r[21:0]}
                                 : {hit_frame, va_r[11:0]};

  // walker fill; an invalidation in the same cycle cancels it so that
  // a walk ending in the flush cycle never lands, and the lookup walks again
  wire dir_ok   = (state_r == xlate_pkg::ST_DIR) & mem_ack &
                  mem_rdata[xlate_pkg::ENT_P];
  wire tbl_ok   = (state_r == xlate_pkg::ST_TBL) & mem_ack &
                  mem_rdata[xlate_pkg::ENT_P];
  wire fill_lg  = dir_ok & mem_rdata[xlate_pkg::ENT_PS];
  wire fill_now = (fill_lg | tbl_ok) & ~any_inv;
  wire walk_np  = mem_ack & ~mem_rdata[xlate_pkg::ENT_P] &
                  (state_r != xlate_pkg::ST_IDLE);

  // next valid mask: kills first, then the new fill
  always_comb begin
    ent_valid_nxt = ent_valid_r & ~kill_vec;
    if (fill_now) begin
      ent_valid_nxt[victim_r] = 1'b1;
    end
  end

  // entry contents; global flag kept from the entry that ends the walk, table entry or large-page directory entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ent_valid_r <= '0;
      victim_r    <= '0;
    end else begin
      ent_valid_r <= ent_valid_nxt;
      if (fill_now) begin
        victim_r <= victim_r + 1'b1;
        ent_tag_r[victim_r]   <= va_r[31:12];
        ent_frame_r[victim_r] <= mem_rdata[31:12];
        ent_large_r[victim_r] <= fill_lg;
        ent_glob_r[victim_r]  <= mem_rdata[xlate_pkg::ENT_G];
        ent_rw_r[victim_r]    <= mem_rdata[xlate_pkg::ENT_RW] & (fill_lg | pde_rw_r);
        ent_us_r[victim_r]    <= mem_rdata[xlate_pkg::ENT_US] & (fill_lg | pde_us_r);
        ent_xd_r[victim_r]    <= mem_rdata[xlate_pkg::ENT_XD] | (~fill_lg & pde_xd_r);
      end
    end
  end

  // walker: idle, lookup, directory read, table read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= xlate_pkg::ST_IDLE;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_paddr <= 32'h0000_0000;
      rsp_fault <= 1'b0;
      rsp_code  <= xlate_pkg::FLT_NONE;
      mem_req   <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      va_r      <= 32'h0000_0000;
      wr_q_r    <= 1'b0;
      user_q_r  <= 1'b0;
      fetch_q_r <= 1'b0;
      pde_rw_r  <= 1'b0;
      pde_us_r  <= 1'b0;
      pde_xd_r  <= 1'b0;
      hits_r    <= 32'h0000_0000;
      misses_r  <= 32'h0000_0000;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_r)
        xlate_pkg::ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            va_r      <= req_vaddr;
            wr_q_r    <= req_write;
            user_q_r  <= req_user;
            fetch_q_r <= req_fetch;
            state_r   <= xlate_pkg::ST_LOOK;
          end
        end
        xlate_pkg::ST_LOOK: begin
          if (!paging_on) begin
            // no paging: linear equals physical, no page checks
            rsp_valid <= 1'b1;
            rsp_paddr <= va_r;
            rsp_fault <= 1'b0;
            rsp_code  <= xlate_pkg::FLT_NONE;
            state_r   <= xlate_pkg::ST_IDLE;
          end else if (hit_any) begin
            // the access is released only with a clean check
            hits_r    <= hits_r + 32'h0000_0001;
            rsp_valid <= 1'b1;
            rsp_fault <= (chk_code != xlate_pkg::FLT_NONE);
            rsp_code  <= chk_code;
            rsp_paddr <= (chk_code != xlate_pkg::FLT_NONE) ? 32'h0000_0000 : hit_pa;
            state_r   <= xlate_pkg::ST_IDLE;
          end else begin
            misses_r <= misses_r + 32'h0000_0001;
            mem_req  <= 1'b1;
            mem_addr <= {root_r[31:12], 12'h000} + {19'h00000, va_r[31:22], 3'h0};
            state_r  <= xlate_pkg::ST_DIR;
          end
        end
        xlate_pkg::ST_DIR: begin
          if (mem_ack) begin
            pde_rw_r <= mem_rdata[xlate_pkg::ENT_RW];
            pde_us_r <= mem_rdata[xlate_pkg::ENT_US];
            pde_xd_r <= mem_rdata[xlate_pkg::ENT_XD];
            if (walk_np || fill_lg) begin
              mem_req <= 1'b0;
            end else begin
              mem_addr <= {mem_rdata[31:12], 12'h000} +
                          {19'h00000, va_r[21:12], 3'h0};
            end
            state_r <= walk_np ? xlate_pkg::ST_IDLE :
                       fill_lg ? xlate_pkg::ST_LOOK : xlate_pkg::ST_TBL;
          end
        end
        xlate_pkg::ST_TBL: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            state_r <= walk_np ? xlate_pkg::ST_IDLE : xlate_pkg::ST_LOOK;
          end
        end
      endcase
      // a not-present entry ends the walk with a fault, nothing installed
      if (walk_np) begin
        rsp_valid <= 1'b1;
        rsp_fault <= 1'b1;
        rsp_code  <= xlate_pkg::FLT_NOTP;
        rsp_paddr <= 32'h0000_0000;
      end
    end
  end

  // bus write side: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      aw_priv_r     <= 1'b0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= xlate_pkg::RESP_OKAY;
      ctrl_r        <= xlate_pkg::CTL_RST;
      root_r        <= xlate_pkg::ROOT_RST;
    end else begin
      s_axi_awready <= ~aw_full_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_full_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        aw_priv_r <= s_axi_awprot[0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // unprivileged or unmapped writes change nothing
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? xlate_pkg::RESP_OKAY : xlate_pkg::RESP_SLVERR;
        if (wr_ok && a_ctrl) begin
          ctrl_r <= ctrl_merge[xlate_pkg::CTL_W-1:0];
        end
      end
      if (root_ld) begin
        root_r <= task_switch ? task_root : root_merge;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
      end
    end
  end

  // bus read side; status shows walker busy and resident entries
  wire [31:0] status_w = {16'h0000, ent_valid_r, 7'h00, ~state_r[0]};
  wire [7:0]  ra = s_axi_araddr;
  wire rd_map = (ra == xlate_pkg::OFF_CTRL) | (ra == xlate_pkg::OFF_ROOT) |
                (ra == xlate_pkg::OFF_INVAL) | (ra == xlate_pkg::OFF_STATUS) |
                (ra == xlate_pkg::OFF_HITS) | (ra == xlate_pkg::OFF_MISSES);
  wire [31:0] rd_mux = (ra == xlate_pkg::OFF_CTRL)   ? ctrl_wide :
                       (ra == xlate_pkg::OFF_ROOT)   ? root_r :
                       (ra == xlate_pkg::OFF_STATUS) ? status_w :
                       (ra == xlate_pkg::OFF_HITS)   ? hits_r :
                       (ra == xlate_pkg::OFF_MISSES) ? misses_r : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= xlate_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_map ? xlate_pkg::RESP_OKAY : xlate_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= ~s_axi_rready;
      s_axi_arready <= s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_hit_no_walk: assert property (
    (state_r == xlate_pkg::ST_LOOK) && paging_on && hit_any |=> rsp_valid && !mem_req)
    else $error("hit started a walk or gave no answer");
  chk_root_flush: assert property (
    root_ld |=> (ent_valid_r & ~(ent_glob_r & {N{$past(glob_en_on)}})) == '0)
    else $error("non-global entry survived root load");
  chk_global_keep: assert property (
    root_ld && glob_en_on && !glob_en_fall && !page_inv
      |=> ($past(ent_valid_r & ent_glob_r) & ~ent_valid_r) == '0)
    else $error("global entry lost on root load");
  chk_glob_flush: assert property (
    glob_en_fall |=> ent_valid_r == '0)
    else $error("global enable clear left entries");
  chk_page_gone: assert property (
    page_inv |=> (ent_valid_r & $past(inv_match)) == '0)
    else $error("page invalidate left matching entry");
  chk_fault_quiet: assert property (
    rsp_valid && rsp_fault |-> rsp_paddr == 32'h0000_0000 && rsp_code != 3'h0)
    else $error("faulting access released an address");
  chk_priv_refuse: assert property (
    wr_fire && !aw_priv_r && !task_switch
      |=> $stable(root_r) && $stable(ctrl_r) && s_axi_bresp == 2'h2)
    else $error("unprivileged write took effect");
  chk_user_class: assert property (
    (state_r == xlate_pkg::ST_LOOK) && paging_on && hit_any && user_q_r && !hit_us
      |=> rsp_fault && rsp_code == 3'h3)
    else $error("user access to supervisor page passed");
endmodule
`default_nettype wire

// ### mem_model.sv
// behavioural memory that serves paging entries to the page walker
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        aclk,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  delay,
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  logic [63:0] mem [logic [31:0]]; // sparse store, absent words read as not present
  logic [3:0]  wait_r  = 4'h0;     // cycles spent on the current request
  int          n_reads = 0;        // reads served, watched by the bench
  // preload or edit one paging entry
  task automatic poke(input logic [31:0] a, input logic [63:0] d);
    mem[a] = d;
  endtask
  // answer after delay cycles; idle data toggles so a stale sample cannot pass
  // an unknown ack or request before reset counts as idle, so no stray answer
  always @(posedge aclk) begin
    if (mem_ack !== 1'b0 || mem_req !== 1'b1) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_r >= delay) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
      n_reads <= n_reads + 1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### translation_buffer_tb.sv
// self-checking bench for the translation buffer
`timescale 1ns/100ps
`default_nettype none
module translation_buffer_tb;
  localparam logic [7:0] A_CTRL = xlate_pkg::OFF_CTRL;   // control register
  localparam logic [7:0] A_ROOT = xlate_pkg::OFF_ROOT;   // root register
  localparam logic [7:0] A_INV  = xlate_pkg::OFF_INVAL;  // page invalidate
  localparam logic [2:0] RD = 3'h0;                      // access kinds: write, user, fetch
  localparam logic [2:0] WR = 3'h4;
  localparam logic [2:0] UR = 3'h2;
  localparam logic [2:0] UW = 3'h6;
  localparam logic [2:0] FE = 3'h1;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [2:0]  awprot = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, task_root = 32'h0, req_vaddr = 32'h0;
  logic [3:0]  mem_delay = 4'h0;
  logic        task_switch = 1'b0, req_valid = 1'b0;
  logic        req_write = 1'b0, req_user = 1'b0, req_fetch = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, req_ready, rsp_valid, rsp_fault;
  logic        mem_req, mem_ack;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rsp_paddr, mem_addr, rd;
  logic [2:0]  rsp_code;
  logic [63:0] mem_rdata;
  logic [31:0] mode [3] = '{32'h0, 32'h1, 32'h2}; // control values that leave paging off
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #2 aclk = ~aclk;
  translation_buffer DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h1), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .task_switch(task_switch), .task_root(task_root), .req_valid(req_valid),
    .req_ready(req_ready), .req_vaddr(req_vaddr), .req_write(req_write),
    .req_user(req_user), .req_fetch(req_fetch), .rsp_valid(rsp_valid),
    .rsp_paddr(rsp_paddr), .rsp_fault(rsp_fault), .rsp_code(rsp_code),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  mem_model MEM (.aclk(aclk), .mem_req(mem_req), .mem_addr(mem_addr), .delay(mem_delay),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // compare a word; four-state equality so unknowns fail
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // compare a bus response code
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s resp %h expected %h", $time, what, got, exp);
    end
  endtask
  // one write; address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic priv);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awprot <= {2'b00, priv};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // one read; data and response taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // one translation, checked against address, code and number of walk reads
  task automatic tx(input logic [31:0] va, input logic [2:0] kind, input logic [31:0] pa,
                    input logic [2:0] code, input int reads);
    int n0;
    n0 = MEM.n_reads;
    req_vaddr <= va;
    {req_write, req_user, req_fetch} <= kind;
    req_valid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rsp_valid !== 1'b1);
    chk_word(rsp_paddr, pa, "paddr");
    chk_word({29'h0, rsp_code}, {29'h0, code}, "fault code");
    chk_word({31'h0, rsp_fault}, {31'h0, code != 3'h0}, "fault flag");
    chk_word(32'(MEM.n_reads - n0), 32'(reads), "walk reads");
  endtask
  // print the counts and the verdict, then stop
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog: the sequence needs a few hundred cycles
  initial begin
    #100000;
    n_mismatch++;
    $display("ERROR at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // main sequence
  initial begin
    MEM.poke(32'h0001_0008, 64'h0000_0000_0002_0007);  // directory: table at 0x20000
    MEM.poke(32'h0001_0010, 64'h0000_0000_00C0_0087);  // directory: large page
    MEM.poke(32'h0002_0018, 64'h0000_0000_0005_5007);  // plain user page
    MEM.poke(32'h0002_0020, 64'h0000_0000_0006_6107);  // global page
    MEM.poke(32'h0002_0028, 64'h0000_0000_0007_7005);  // read-only page
    MEM.poke(32'h0002_0030, 64'h0000_0000_0008_8003);  // supervisor page
    MEM.poke(32'h0002_0038, 64'h8000_0000_0009_9007);  // no-execute page
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(A_CTRL);
    chk_word(rd, 32'h0, "ctrl after reset");
    axi_rd(8'h18);
    chk_resp(rs, xlate_pkg::RESP_SLVERR, "unmapped read");
    // paging stays off unless both enables are set
    foreach (mode[i]) begin
      axi_wr(A_CTRL, mode[i], 1'b1);
      tx(32'h0040_6123, UR, 32'h0040_6123, 3'h0, 0);
    end
    $display("test paging_off done");
    axi_wr(A_ROOT, 32'h0001_0000, 1'b1);
    axi_wr(A_CTRL, 32'h0000_000B, 1'b1);
    tx(32'h0040_3123, RD, 32'h0005_5123, 3'h0, 2);
    tx(32'h0040_3FFC, UW, 32'h0005_5FFC, 3'h0, 0);
    tx(32'h0081_2345, RD, 32'h00C1_2345, 3'h0, 1);
    tx(32'h0040_4010, RD, 32'h0006_6010, 3'h0, 2);
    $display("test walk_and_hit done");
    // root reloads keep only global entries
    axi_wr(A_ROOT, 32'h0001_0000, 1'b1);
    chk_resp(rs, xlate_pkg::RESP_OKAY, "root write");
    tx(32'h0040_3123, RD, 32'h0005_5123, 3'h0, 2);
    tx(32'h0040_4010, RD, 32'h0006_6010, 3'h0, 0);
    task_root <= 32'h0001_0000;
    task_switch <= 1'b1;
    @(posedge aclk);
    task_switch <= 1'b0;
    @(posedge aclk);
    tx(32'h0040_3123, RD, 32'h0005_5123, 3'h0, 2);
    tx(32'h0040_4010, RD, 32'h0006_6010, 3'h0, 0);
    $display("test root_reload done");
    // unprivileged invalidate is refused, privileged one drops even a global page
    axi_wr(A_INV, 32'h0040_4000, 1'b0);
    chk_resp(rs, xlate_pkg::RESP_SLVERR, "user invalidate");
    tx(32'h0040_4010, RD, 32'h0006_6010, 3'h0, 0);
    axi_wr(A_INV, 32'h0040_4000, 1'b1);
    tx(32'h0040_4010, RD, 32'h0006_6010, 3'h0, 2);
    tx(32'h0040_3123, RD, 32'h0005_5123, 3'h0, 0);
    MEM.poke(32'h0002_0018, 64'h0000_0000_0005_A007);
    axi_wr(A_INV, 32'h0040_3000, 1'b1);
    tx(32'h0040_3123, RD, 32'h0005_A123, 3'h0, 2);
    axi_wr(A_CTRL, 32'h0000_0003, 1'b1);
    tx(32'h0040_4010, RD, 32'h0006_6010, 3'h0, 2);
    $display("test invalidate done");
    // permission checks with a slow memory
    mem_delay <= 4'h3;
    tx(32'h0040_5000, UR, 32'h0007_7000, 3'h0, 2);
    tx(32'h0040_5000, UW, 32'h0000_0000, 3'h2, 0);
    tx(32'h0040_5000, WR, 32'h0007_7000, 3'h0, 0);
    tx(32'h0040_6000, UR, 32'h0000_0000, 3'h3, 2);
    tx(32'h0040_7000, FE, 32'h0009_9000, 3'h0, 2);
    tx(32'h0040_8000, RD, 32'h0000_0000, 3'h1, 2);
    axi_wr(A_CTRL, 32'h0000_0017, 1'b1);
    tx(32'h0040_5000, WR, 32'h0000_0000, 3'h2, 0);
    tx(32'h0040_7000, FE, 32'h0000_0000, 3'h4, 0);
    $display("test protection done");
    // eleven walks install and then hit, nine lookups hit directly, twelve miss
    axi_rd(xlate_pkg::OFF_HITS);
    chk_word(rd, 32'h0000_0014, "hit count");
    axi_rd(xlate_pkg::OFF_MISSES);
    chk_word(rd, 32'h0000_000C, "miss count");
    $display("test counters done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
